// ==== rtl/irq_reset_boot.sv ====
// Interrupt, reset, boot-mode and branch-condition logic of the core.
// Assumes the sequencer pulses vector_fetch_done and gives the pipe phase.
// Contract
// - Acknowledge high during vector fetch
// - Acknowledge floats when output-disable low
// - User interrupts masked individually and globally
// - Flag register shows pending user interrupts
// - NMI ignores all masks
// - NMI traps to its own vector
// - Reset low halts and reinitialises
// - Execution restarts at 0FF80h
// - Select low: ROM in upper 16K
// - Select high: ROM removed
// - Select sampled at reset; mode bit overrides
// - Branch input low executes, high skips
// - Decode phase for conditional-execute, else read
// - Keepers off at reset, bit controls
// - Data bus released during reset
// - External flag high at reset
`timescale 1ns/10ps
module irq_reset_boot (
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  // Board pins
  input  wire logic [irq_pins_pkg::NUM_USER_IRQ-1:0]  user_interrupt_inputs,
  input  wire logic                                   nmi_in,
  input  wire logic                                   cpu_reset_in,
  input  wire logic                                   rom_map_select_in,
  input  wire logic                                   branch_condition_in,
  input  wire logic                                   output_disable_n,
  // Software state
  input  wire logic [irq_pins_pkg::NUM_USER_IRQ-1:0]  interrupt_mask_reg,
  input  wire logic                                   global_irq_mask_bit,
  input  wire logic                                   mode_override_valid,
  input  wire logic                                   mode_override_bit,
  input  wire logic                                   keeper_write,
  input  wire logic                                   bus_keeper_enable_bit,
  input  wire logic                                   flag_write,
  input  wire logic                                   flag_value,
  input  wire logic [irq_pins_pkg::NUM_USER_IRQ-1:0]  flag_clear,
  // Pipeline sequencer
  input  wire logic                                   vector_fetch_done,
  input  wire logic                                   branch_sample,
  input  wire logic                                   cond_exec_op,
  input  wire irq_pins_pkg::pipe_phase_t              pipe_phase,
  // Outputs
  output logic                                        interrupt_acknowledge_out,
  output logic                                        interrupt_acknowledge_oe,
  output logic [irq_pins_pkg::ADDR_W-1:0]             vector_address,
  output logic                                        vector_fetch,
  output logic                                        cpu_halt,
  output logic [irq_pins_pkg::ADDR_W-1:0]             restart_address,
  output logic                                        restart_pulse,
  output logic                                        rom_mapped,
  output logic [irq_pins_pkg::NUM_USER_IRQ-1:0]       interrupt_flag_reg,
  output logic                                        execute_conditional,
  output logic                                        bus_keeper_on,
  output logic                                        data_bus_oe_allow,
  output logic                                        external_flag_out
);
  import irq_pins_pkg::*;

  pin_sync_if sync ();

  pin_sync u_sync (
    .clk           (clk),
    .rst           (rst),
    .user_irq_pins (user_interrupt_inputs),
    .nmi_pin       (nmi_in),
    .reset_pin_n   (cpu_reset_in),
    .branch_pin_n  (branch_condition_in),
    .rom_map_pin   (rom_map_select_in),
    .sync          (sync)
  );

  logic        nmi_prev;
  logic        in_reset;
  logic        oe_s1;
  logic        oe_s2;
  boot_mode_t  latched_mode;
  logic [1:0]  ack_left;
  logic        nmi_pending;
  logic [NUM_USER_IRQ-1:0] irq_prev;
  logic [NUM_USER_IRQ-1:0] enabled;
  logic [NUM_USER_IRQ-1:0] next_flags;
  logic        user_hit;
  logic [1:0]  user_sel;
  logic        take;

  assign in_reset = ~sync.reset_n;

  // Output-disable is a pin too
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_s1 <= 1'h0;
      oe_s2 <= 1'h0;
    end else begin
      oe_s1 <= output_disable_n;
      oe_s2 <= oe_s1;
    end
  end

  always_comb begin
    next_flags = (interrupt_flag_reg & ~flag_clear) |
                 (sync.user_irq & ~irq_prev);
  end

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      interrupt_flag_reg <= '0;
      irq_prev           <= '0;
    end else begin
      irq_prev <= sync.user_irq;
      if (take && !nmi_pending && user_hit)
        interrupt_flag_reg <= next_flags & ~(4'h1 << user_sel) | (sync.user_irq & ~irq_prev);
      else
        interrupt_flag_reg <= next_flags;
    end
  end

  assign enabled = interrupt_flag_reg & interrupt_mask_reg & {NUM_USER_IRQ{~global_irq_mask_bit}};

  always_comb begin
    user_hit = 1'b0;
    user_sel = 2'h0;
    for (int i = NUM_USER_IRQ - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        user_hit = 1'b1;
        user_sel = 2'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      nmi_prev    <= 1'h0;
      nmi_pending <= 1'h0;
    end else begin
      nmi_prev <= sync.nmi;
      if (sync.nmi && !nmi_prev)
        nmi_pending <= 1'h1;
      else if (take)
        nmi_pending <= 1'h0;
    end
  end

  assign take = !vector_fetch && (nmi_pending || user_hit);

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      vector_fetch              <= 1'h0;
      interrupt_acknowledge_out <= 1'h0;
      vector_address            <= RESET_VECTOR;
      ack_left                  <= 2'h0;
    end else if (take) begin
      vector_fetch              <= 1'h1;
      interrupt_acknowledge_out <= 1'h1;
      ack_left                  <= 2'(ACK_CYCLES);
      vector_address <= nmi_pending ? NMI_VECTOR :
                        USER_VEC_BASE + 16'(user_sel) * 16'(USER_VEC_STRIDE);
    end else if (vector_fetch && (vector_fetch_done || ack_left == 2'h1)) begin
      vector_fetch              <= 1'h0;
      interrupt_acknowledge_out <= 1'h0;
      ack_left                  <= 2'h0;
    end else if (ack_left != 2'h0) begin
      ack_left <= ack_left - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      interrupt_acknowledge_oe <= 1'h0;
    else
      interrupt_acknowledge_oe <= oe_s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_halt          <= 1'h1;
      restart_pulse     <= 1'h0;
      restart_address   <= RESET_VECTOR;
      data_bus_oe_allow <= 1'h0;
    end else begin
      cpu_halt          <= in_reset;
      restart_pulse     <= cpu_halt && !in_reset;
      restart_address   <= RESET_VECTOR;
      data_bus_oe_allow <= !in_reset && oe_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      latched_mode <= mode_microprocessor;
    else if (in_reset)
      latched_mode <= sync.rom_map ? mode_microprocessor : mode_microcomputer;
    else if (mode_override_valid)
      latched_mode <= mode_override_bit ? mode_microprocessor : mode_microcomputer;
  end

  always_ff @(posedge clk) begin
    if (rst)
      rom_mapped <= 1'h0;
    else
      rom_mapped <= (latched_mode == mode_microcomputer);
  end

  always_ff @(posedge clk) begin
    if (rst || in_reset)
      execute_conditional <= 1'h0;
    else if (branch_sample &&
             ((cond_exec_op && pipe_phase == phase_decode) ||
              (!cond_exec_op && pipe_phase == phase_read)))
      execute_conditional <= !sync.branch_n;
  end

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      bus_keeper_on     <= KEEPER_RESET;
      external_flag_out <= FLAG_RESET;
    end else begin
      if (keeper_write)
        bus_keeper_on <= bus_keeper_enable_bit;
      if (flag_write)
        external_flag_out <= flag_value;
    end
  end
endmodule

// ==== rtl/irq_pins_pkg.sv ====
// Constants and types shared by the interrupt, reset and boot pin logic.
// Assumes a single core clock; all pins are synchronised inside the block.
package irq_pins_pkg;
  localparam int          NUM_USER_IRQ    = 4;
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] RESET_VECTOR    = 16'hff80;
  localparam logic [15:0] NMI_VECTOR      = 16'hff88;
  localparam logic [15:0] USER_VEC_BASE   = 16'hffc0;
  localparam int          USER_VEC_STRIDE = 4;
  localparam int          SYNC_STAGES     = 2;
  localparam int          ACK_CYCLES      = 2;
  localparam logic [3:0]  MASK_RESET      = 4'h0;
  localparam logic        GLOBAL_MASK_RST = 1'h1;
  localparam logic        KEEPER_RESET    = 1'h0;
  localparam logic        FLAG_RESET      = 1'h1;

  typedef enum logic [1:0] {
    mode_microcomputer,
    mode_microprocessor
  } boot_mode_t;

  typedef enum logic [1:0] {
    phase_decode,
    phase_read,
    phase_other
  } pipe_phase_t;
endpackage

// ==== rtl/pin_sync_if.sv ====
// Bundle of synchronised pin levels passed from the synchroniser to the core.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
interface pin_sync_if;
  logic [3:0] user_irq;
  logic       nmi;
  logic       reset_n;
  logic       branch_n;
  logic       rom_map;
  modport src (output user_irq, output nmi, output reset_n, output branch_n, output rom_map);
  modport dst (input user_irq, input nmi, input reset_n, input branch_n, input rom_map);
endinterface

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for the asynchronous board pins.
// Assumes pins are levels held for at least a few core clocks.
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Raw pins
  input  wire logic [3:0] user_irq_pins,
  input  wire logic       nmi_pin,
  input  wire logic       reset_pin_n,
  input  wire logic       branch_pin_n,
  input  wire logic       rom_map_pin,
  // Synchronised levels
  pin_sync_if.src         sync
);
  logic [7:0] stage1;
  logic [7:0] stage2;

  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle pin levels, so no false edge shows up when reset ends
      stage1 <= 8'he0;
      stage2 <= 8'he0;
    end else begin
      stage1 <= {rom_map_pin, branch_pin_n, reset_pin_n, nmi_pin, user_irq_pins};
      stage2 <= stage1;
    end
  end

  assign sync.user_irq = stage2[3:0];
  assign sync.nmi      = stage2[4];
  assign sync.reset_n  = stage2[5];
  assign sync.branch_n = stage2[6];
  assign sync.rom_map  = stage2[7];
endmodule

// ==== dv/irq_reset_boot_asserts.sv ====
// Checker for the interrupt, reset and boot pin logic.
// Sees only the top-level ports; bound onto every instance below.
`timescale 1ns/10ps
module irq_reset_boot_chk (
  // Clock and reset
  input wire logic                            clk,
  input wire logic                            rst,
  // Pins and sequencer strobe
  input wire logic                            cpu_reset_in,
  input wire logic                            output_disable_n,
  input wire logic                            vector_fetch_done,
  // Observed outputs
  input wire logic                            interrupt_acknowledge_out,
  input wire logic                            interrupt_acknowledge_oe,
  input wire logic [irq_pins_pkg::ADDR_W-1:0] vector_address,
  input wire logic                            vector_fetch,
  input wire logic                            cpu_halt,
  input wire logic [irq_pins_pkg::ADDR_W-1:0] restart_address,
  input wire logic                            restart_pulse,
  input wire logic                            bus_keeper_on,
  input wire logic                            data_bus_oe_allow,
  input wire logic                            external_flag_out
);
  import irq_pins_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_floats: assert property (!output_disable_n |-> ##[1:5] !interrupt_acknowledge_oe)
    else $error("acknowledge still driven");
  a_ack_short: assert property ($rose(interrupt_acknowledge_out) |->
      ##[1:2] !interrupt_acknowledge_out)
    else $error("acknowledge too long");
  a_ack_fetch: assert property (interrupt_acknowledge_out |-> vector_fetch)
    else $error("acknowledge outside vector fetch");
  a_ack_done_ends: assert property (vector_fetch_done && interrupt_acknowledge_out
      |=> !interrupt_acknowledge_out)
    else $error("acknowledge outlives fetch done");
  a_vector_range: assert property ($rose(interrupt_acknowledge_out) |->
      vector_address == NMI_VECTOR || vector_address[15:4] == USER_VEC_BASE[15:4])
    else $error("vector outside table");
  a_reset_state: assert property ($fell(rst) |->
      cpu_halt && external_flag_out && !bus_keeper_on && !data_bus_oe_allow)
    else $error("bad state at reset release");
  a_restart_addr: assert property (restart_pulse |-> restart_address == RESET_VECTOR)
    else $error("restart address wrong");
  a_restart_once: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
  a_restart_after: assert property ($rose(cpu_reset_in) |-> ##[1:5] restart_pulse)
    else $error("no restart after pin reset");
  a_bus_release: assert property (!cpu_reset_in |->
      ##[1:5] (!data_bus_oe_allow && cpu_halt))
    else $error("bus held during pin reset");
endmodule

bind irq_reset_boot irq_reset_boot_chk chk (
  .clk                       (clk),
  .rst                       (rst),
  .cpu_reset_in              (cpu_reset_in),
  .output_disable_n          (output_disable_n),
  .vector_fetch_done         (vector_fetch_done),
  .interrupt_acknowledge_out (interrupt_acknowledge_out),
  .interrupt_acknowledge_oe  (interrupt_acknowledge_oe),
  .vector_address            (vector_address),
  .vector_fetch              (vector_fetch),
  .cpu_halt                  (cpu_halt),
  .restart_address           (restart_address),
  .restart_pulse             (restart_pulse),
  .bus_keeper_on             (bus_keeper_on),
  .data_bus_oe_allow         (data_bus_oe_allow),
  .external_flag_out         (external_flag_out)
);

// ==== dv/board_pins.sv ====
// Board-side model: interrupt sources, reset switch and mode strap.
// Pins change only just after a falling clock edge.
`timescale 1ns/10ps
module board_pins (
  // Clock
  input  wire logic  clk,
  // Pins toward the core
  output logic [3:0] user_interrupt_inputs,
  output logic       nmi_in,
  output logic       cpu_reset_in,
  output logic       rom_map_select_in,
  output logic       branch_condition_in,
  output logic       output_disable_n
);
  initial begin
    user_interrupt_inputs = 4'h0;
    nmi_in = 1'h0;
    cpu_reset_in = 1'h1;
    rom_map_select_in = 1'h1;
    branch_condition_in = 1'h1;
    output_disable_n = 1'h1;
  end
  task automatic assert_reset(input logic strap);
    rom_map_select_in = strap;
    @(negedge clk);
    cpu_reset_in = 1'h0;
  endtask
endmodule

// ==== dv/tb_interrupt_reset_boot.sv ====
// Self-checking bench for the interrupt, reset and boot pin logic.
// Board pins come from board_pins; software and sequencer inputs from here.
`timescale 1ns/10ps
module tb_interrupt_reset_boot;
  import irq_pins_pkg::*;
  logic clk = 0, rst = 1, b, ack_seen = 0, early_done = 0;
  logic [3:0] user_interrupt_inputs, interrupt_mask_reg = 0, flag_clear = 0, pat;
  logic nmi_in, cpu_reset_in, rom_map_select_in, branch_condition_in, output_disable_n;
  logic global_irq_mask_bit = 1, mode_override_valid = 0, mode_override_bit = 0;
  logic keeper_write = 0, bus_keeper_enable_bit = 0, flag_write = 0, flag_value = 0;
  logic vector_fetch_done = 0, branch_sample = 0, cond_exec_op = 0;
  pipe_phase_t pipe_phase = phase_other;
  logic interrupt_acknowledge_out, interrupt_acknowledge_oe, vector_fetch, cpu_halt;
  logic restart_pulse, rom_mapped, execute_conditional, bus_keeper_on;
  logic data_bus_oe_allow, external_flag_out;
  logic [15:0] vector_address, restart_address;
  logic [3:0] interrupt_flag_reg;
  int errors = 0, num_checks = 0, cyc = 0;
  logic [15:0] expq[$];

  always #5 clk = ~clk;
  board_pins board (.*);
  irq_reset_boot dut (.*);

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Queue model: each rising acknowledge consumes the oldest expected vector
  always @(negedge clk) begin
    if (interrupt_acknowledge_out === 1'h1 && !ack_seen) begin
      if (expq.size() == 0) chk(1'h0, "unexpected acknowledge");
      else chk(vector_address === expq.pop_front(), "vector address");
    end
    // Some fetches end early through the sequencer strobe
    vector_fetch_done = early_done && interrupt_acknowledge_out === 1'h1 && !ack_seen;
    ack_seen = (interrupt_acknowledge_out === 1'h1);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(73908));
    wait_n(12);
    chk(cpu_halt === 1'h1 && interrupt_acknowledge_oe === 1'h0, "halt in reset");
    chk(external_flag_out === 1'h1 && bus_keeper_on === 1'h0, "flag or keeper");
    chk(restart_address === RESET_VECTOR, "restart address");
    rst = 0;
    wait_n(4);
    interrupt_mask_reg = 4'hf;
    global_irq_mask_bit = 1'h0;
    repeat (3) begin
      pat = 4'($urandom % 15) + 4'h1;
      early_done = 1'($urandom);
      for (int i = 0; i < 4; i++)
        if (pat[i]) expq.push_back(USER_VEC_BASE + 16'(USER_VEC_STRIDE * i));
      board.user_interrupt_inputs = pat;
      wait_n(24);
      board.user_interrupt_inputs = 4'h0;
      wait_n(4);
      chk(expq.size() == 0, "all requests served in order");
    end
    global_irq_mask_bit = 1'h1;
    board.user_interrupt_inputs = 4'h5;
    wait_n(8);
    chk(interrupt_flag_reg === 4'h5, "flags polled while masked");
    expq.push_back(USER_VEC_BASE);
    interrupt_mask_reg = 4'h1;
    global_irq_mask_bit = 1'h0;
    wait_n(8);
    chk(interrupt_flag_reg === 4'h4 && expq.size() == 0, "masked flag kept");
    flag_clear = 4'h4;
    wait_n(1);
    flag_clear = 4'h0;
    wait_n(3);
    chk(interrupt_flag_reg === 4'h0, "flag cleared");
    board.user_interrupt_inputs = 4'h0;
    global_irq_mask_bit = 1'h1;
    interrupt_mask_reg = 4'h0;
    expq.push_back(NMI_VECTOR);
    board.nmi_in = 1'h1;
    wait_n(8);
    board.nmi_in = 1'h0;
    chk(expq.size() == 0, "nmi taken through masks");
    wait_n(4);
    interrupt_mask_reg = 4'hf;
    global_irq_mask_bit = 1'h0;
    expq.push_back(NMI_VECTOR);
    expq.push_back(USER_VEC_BASE + 16'(USER_VEC_STRIDE));
    board.user_interrupt_inputs = 4'h2;
    board.nmi_in = 1'h1;
    wait_n(12);
    board.user_interrupt_inputs = 4'h0;
    board.nmi_in = 1'h0;
    chk(expq.size() == 0, "nmi served before user");
    board.output_disable_n = 1'h0;
    wait_n(6);
    chk(interrupt_acknowledge_oe === 1'h0 && data_bus_oe_allow === 1'h0, "outputs float");
    board.output_disable_n = 1'h1;
    wait_n(6);
    chk(interrupt_acknowledge_oe === 1'h1 && data_bus_oe_allow === 1'h1, "driven");
    for (int i = 0; i < 4; i++) begin
      b = 1'($urandom);
      board.branch_condition_in = b;
      wait_n(4);
      cond_exec_op = i[0];
      pipe_phase = i[0] ? phase_decode : phase_read;
      branch_sample = 1'h1;
      wait_n(1);
      branch_sample = 1'h0;
      wait_n(2);
      chk(execute_conditional === ~b, "branch decision");
      // Other phase for this kind of op: the last decision must stand
      board.branch_condition_in = ~b;
      pipe_phase = i[0] ? phase_read : phase_decode;
      wait_n(4);
      branch_sample = 1'h1;
      wait_n(1);
      branch_sample = 1'h0;
      wait_n(2);
      chk(execute_conditional === ~b, "branch ignored in other phase");
    end
    keeper_write = 1'h1;
    bus_keeper_enable_bit = 1'h1;
    flag_write = 1'h1;
    flag_value = 1'h0;
    wait_n(1);
    keeper_write = 1'h0;
    flag_write = 1'h0;
    wait_n(2);
    chk(bus_keeper_on === 1'h1, "keeper enabled");
    chk(external_flag_out === 1'h0, "flag written low");
    for (int m = 0; m < 2; m++) begin
      board.assert_reset(1'(m));
      wait_n(6);
      chk(cpu_halt === 1'h1 && data_bus_oe_allow === 1'h0 && bus_keeper_on === 1'h0 &&
          external_flag_out === 1'h1, "pin reset");
      board.cpu_reset_in = 1'h1;
      wait_n(6);
      chk(rom_mapped === (m == 0), "boot mode");
      board.rom_map_select_in = 1'(m == 0);
      wait_n(6);
      chk(rom_mapped === (m == 0) && cpu_halt === 1'h0, "strap ignored after reset");
    end
    mode_override_bit = 1'h0;
    mode_override_valid = 1'h1;
    wait_n(1);
    mode_override_valid = 1'h0;
    wait_n(2);
    chk(rom_mapped === 1'h1, "mode bit overrides strap");
    stop_test();
  end
endmodule
